// *** rtl/lpt_regs.svh ***
// Timing constants and encodings for the load pipe timing model
// Overview of operation
// - Figures assume a level 1 data cache hit
// - Unaligned 64-bit straddle adds one cycle
// - Simple loads 3 (2 forwarded), 1/cycle, slots 11
// - Minus or complex shift: 5 (4), 1/3, 01
// - Writeback base ready 1, or 3 complex
// - Pointer chase forward cuts one cycle
// - Dual word load always issues alone
// - Multi load N=(regs+1)/2, 3+N-1, 1/N
// - Program counter loads flush; 8, 10, 8+N-1
// - Preload 1 cycle, complex 3 at 1/3
// - Acquire loads 3 (2), slot 01; pairs alone
// - Pair X 4 (3) 1/2 01, alone with writeback; W 3 (2) alone
// - Indexed pair: X 4 (3),2; W 3 (2),1
// - Signed word pair 3, no forward, alone
`ifndef LPT_REGS_SVH
`define LPT_REGS_SVH
`define LPT_LAT_SIMPLE   5'h03
`define LPT_LAT_COMPLEX  5'h05
`define LPT_LAT_PAIR_X   5'h04
`define LPT_LAT_PRE_CPX  5'h03
`define LPT_LAT_PRE      5'h01
`define LPT_LAT_BRANCH   5'h08
`define LPT_LAT_BR_CPX   5'h0a
`define LPT_WB_SIMPLE    5'h01
`define LPT_WB_COMPLEX   5'h03
`define LPT_WB_PAIR_X    5'h02
`define LPT_RPT_ONE      5'h01
`define LPT_RPT_TWO      5'h02
`define LPT_RPT_THREE    5'h03
`define LPT_DUAL_BOTH    2'h3
`define LPT_DUAL_YOUNG   2'h1
`define LPT_DUAL_NONE    2'h0
`define LPT_DUAL_OLD_BIT 1
`define LPT_DUAL_YNG_BIT 0
`endif

// *** rtl/lpt_pkg.sv ***
// Types for the load pipe timing model
package lpt_pkg;
  // Load classes presented by the issue logic
  typedef enum logic [3:0] {
    LPT_SINGLE      = 4'h0,
    LPT_SINGLE_CPX  = 4'h1,
    LPT_PRELOAD     = 4'h2,
    LPT_PRELOAD_CPX = 4'h3,
    LPT_ACQUIRE     = 4'h4,
    LPT_ACQ_PAIR    = 4'h5,
    LPT_DUAL_WORD   = 4'h6,
    LPT_PAIR_W      = 4'h7,
    LPT_PAIR_X      = 4'h8,
    LPT_PAIR_SW     = 4'h9,
    LPT_MULTI       = 4'ha
  } lpt_class_e;
  // One issue request
  typedef struct packed {
    lpt_class_e  cls;
    logic        wback;
    logic        writes_pc;
    logic        fwd_ok;
    logic        unaligned;
    logic [4:0]  nregs;
  } lpt_req_s;
  // Timing figures for one request
  typedef struct packed {
    logic [4:0] lat;
    logic [4:0] wb_lat;
    logic [4:0] repeat_gap;
    logic [1:0] slots;
    logic       has_wb;
    logic       flush;
  } lpt_timing_s;
  // Per-counter state
  typedef enum logic [1:0] {
    LPT_IDLE = 2'b01,
    LPT_RUN  = 2'b10
  } lpt_cnt_e;
endpackage

// *** rtl/lpt_decode.sv ***
// Combinational timing table for one load request
`timescale 1ns/1ps
`include "lpt_regs.svh"
module lpt_decode
  import lpt_pkg::*;
(
  // Request in
  input  wire lpt_req_s    req,
  // Figures out
  output lpt_timing_s      tim
);
  logic [4:0] n_beats;   // Beat count of a multi load
  logic       cut;       // Forward path applies

  // Table lookup
  always_comb begin
    n_beats = 5'((6'(req.nregs) + 6'h01) >> 1);
    cut     = req.fwd_ok;
    tim     = '0;
    tim.repeat_gap = `LPT_RPT_ONE;
    tim.slots      = `LPT_DUAL_BOTH;
    tim.has_wb     = req.wback;
    tim.wb_lat     = `LPT_WB_SIMPLE;
    case (req.cls)
      LPT_SINGLE: begin
        tim.lat = `LPT_LAT_SIMPLE;
      end
      LPT_SINGLE_CPX: begin
        tim.lat        = `LPT_LAT_COMPLEX;
        tim.repeat_gap = `LPT_RPT_THREE;
        tim.slots      = `LPT_DUAL_YOUNG;
        tim.wb_lat     = `LPT_WB_COMPLEX;
      end
      LPT_PRELOAD: begin
        tim.lat = `LPT_LAT_PRE;
        cut     = 1'b0;
      end
      LPT_PRELOAD_CPX: begin
        tim.lat        = `LPT_LAT_PRE_CPX;
        tim.repeat_gap = `LPT_RPT_THREE;
        tim.slots      = `LPT_DUAL_YOUNG;
        cut            = 1'b0;
      end
      LPT_ACQUIRE: begin
        tim.lat   = `LPT_LAT_SIMPLE;
        tim.slots = `LPT_DUAL_YOUNG;
      end
      LPT_ACQ_PAIR: begin
        tim.lat   = `LPT_LAT_SIMPLE;
        tim.slots = `LPT_DUAL_NONE;
      end
      LPT_DUAL_WORD: begin
        tim.lat   = `LPT_LAT_SIMPLE;
        tim.slots = `LPT_DUAL_NONE;
      end
      LPT_PAIR_W: begin
        tim.lat   = `LPT_LAT_SIMPLE;
        tim.slots = `LPT_DUAL_NONE;
      end
      LPT_PAIR_X: begin
        tim.lat        = `LPT_LAT_PAIR_X;
        tim.repeat_gap = `LPT_RPT_TWO;
        tim.slots      = req.wback ? `LPT_DUAL_NONE
                                   : `LPT_DUAL_YOUNG;
        tim.wb_lat     = `LPT_WB_PAIR_X;
      end
      LPT_PAIR_SW: begin
        tim.lat   = `LPT_LAT_SIMPLE;
        tim.slots = `LPT_DUAL_NONE;
        cut       = 1'b0;
      end
      LPT_MULTI: begin
        tim.lat        = 5'(`LPT_LAT_SIMPLE + n_beats - 5'h01);
        tim.repeat_gap = n_beats;
        tim.slots      = `LPT_DUAL_NONE;
        tim.wb_lat     = n_beats;
      end
      default: begin
        tim.lat = `LPT_LAT_SIMPLE;
      end
    endcase
    // Program counter writers: flush, branch latency (8, 10 complex, 8+N-1 multi), alone
    if (req.writes_pc) begin
      tim.flush = 1'b1;
      tim.slots = `LPT_DUAL_NONE;
      cut       = 1'b0;
      if (req.cls == LPT_MULTI)
        tim.lat = 5'(`LPT_LAT_BRANCH + n_beats - 5'h01);
      else if (req.cls == LPT_SINGLE_CPX)
        tim.lat = `LPT_LAT_BR_CPX;
      else
        tim.lat = `LPT_LAT_BRANCH;
      tim.repeat_gap = tim.lat;
    end
    if (cut)
      tim.lat = 5'(tim.lat - 5'h01);
    if (req.unaligned)
      tim.lat = 5'(tim.lat + 5'h01);
  end
endmodule

// *** rtl/lpt_countdown.sv ***
// Loadable down counter that pulses when it reaches zero
`timescale 1ns/1ps
module lpt_countdown
  import lpt_pkg::*;
(
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  // Control
  input  wire logic       load,
  input  wire logic [4:0] count,
  // Status
  output logic            busy,
  output logic            done
);
  lpt_cnt_e   state, next_state;   // Idle or counting
  logic [4:0] cnt, next_cnt;       // Cycles left
  logic       next_done;           // Expiry pulse

  // Next state
  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    next_done  = 1'b0;
    case (state)
      LPT_IDLE: begin
        next_state = LPT_IDLE;
      end
      LPT_RUN: begin
        if (cnt == 5'h00) begin
          next_done  = 1'b1;
          next_state = LPT_IDLE;
        end else begin
          next_cnt = 5'(cnt - 5'h01);
        end
      end
      default: next_state = LPT_IDLE;
    endcase
    // A new load restarts the count; an older count expiring on the same edge still pulses
    if (load) begin
      if (count == 5'h00) begin
        // Zero count expires at the loading edge itself
        next_done  = 1'b1;
        next_state = LPT_IDLE;
      end else begin
        next_state = LPT_RUN;
        next_cnt   = 5'(count - 5'h01);
      end
    end
  end

  // Registers
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state <= LPT_IDLE;
      cnt   <= 5'h00;
      done  <= 1'b0;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
      done  <= next_done;
    end
  end

  assign busy = (state == LPT_RUN);
endmodule

// *** rtl/lpt_load_timing.sv ***
// Load pipe timing model: issue gating, result and writeback timing
`timescale 1ns/1ps
`include "lpt_regs.svh"
module lpt_load_timing
  import lpt_pkg::*;
(
  // Clock and reset
  input  wire logic     sys_clk,
  input  wire logic     sys_rst,
  // Issue request and slot
  input  wire logic     req_valid,
  input  wire lpt_req_s req,
  input  wire logic     req_young,
  input  wire logic     req_paired,
  input  wire logic     cache_hit,
  // Issue answer
  output logic          req_accept,
  output logic          req_stall,
  // Completion
  output logic          data_ready,
  output logic          base_ready,
  output logic          pipe_flush
);
  lpt_timing_s tim;                       // Figures for the request
  logic        slot_ok;                   // Slot legal for class
  logic        gap_clear;                 // Repeat spacing met
  logic        take;                      // Request accepted now
  logic [4:0]  gap, next_gap;             // Cycles until next issue
  logic        flush_pend, next_flush_pend;
  logic        data_done, base_done;      // Counter expiry pulses
  logic        next_accept, next_stall;
  logic        next_flush;

  // Class table
  lpt_decode u_decode (
    .req (req),
    .tim (tim)
  );

  // Slot check: bit 1 older slot, bit 0 younger
  always_comb begin
    if (!req_paired)
      slot_ok = 1'b1;
    else if (req_young)
      slot_ok = tim.slots[`LPT_DUAL_YNG_BIT];
    else
      slot_ok = tim.slots[`LPT_DUAL_OLD_BIT];
  end

  // Only hits are timed; misses are refused
  assign gap_clear = (gap == 5'h00);
  assign take      = req_valid && cache_hit && slot_ok
                     && gap_clear && !flush_pend;

  // Repeat spacing and flush tracking
  always_comb begin
    next_gap        = (gap != 5'h00) ? 5'(gap - 5'h01) : 5'h00;
    next_flush_pend = flush_pend;
    next_flush      = 1'b0;
    if (take) begin
      next_gap = 5'(tim.repeat_gap - 5'h01);
      if (tim.flush)
        next_flush_pend = 1'b1;
    end
    if (flush_pend && data_done) begin
      next_flush      = 1'b1;
      next_flush_pend = 1'b0;
    end
    next_accept = take;
    next_stall  = req_valid && !take;
  end

  // Registers
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      gap        <= 5'h00;
      flush_pend <= 1'b0;
      req_accept <= 1'b0;
      req_stall  <= 1'b0;
      pipe_flush <= 1'b0;
    end else begin
      gap        <= next_gap;
      flush_pend <= next_flush_pend;
      req_accept <= next_accept;
      req_stall  <= next_stall;
      pipe_flush <= next_flush;
    end
  end

  // Expiry flops drive the completion pins directly, no extra stage
  assign data_ready = data_done;
  assign base_ready = base_done;

  // Result latency timer
  lpt_countdown u_data (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .load    (take),
    .count   (5'(tim.lat - 5'h01)),
    .busy    (),
    .done    (data_done)
  );

  // Base writeback timer, parallel with the access
  lpt_countdown u_base (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .load    (take && tim.has_wb),
    .count   (5'(tim.wb_lat - 5'h01)),
    .busy    (),
    .done    (base_done)
  );
endmodule

// *** test/lpt_cache_model.sv ***
// Cache hit model facing the load timing block
`timescale 1ns/1ps
module lpt_cache_model (
  // Miss command from the bench
  input  wire logic miss,
  // Hit indication
  output logic      cache_hit
);
  // Hit unless the bench asks for a miss
  assign cache_hit = ~miss;
endmodule

// *** test/lpt_load_timing_chk.sv ***
// Port assertions for the load timing block
`timescale 1ns/1ps
module lpt_load_timing_chk
  import lpt_pkg::*;
(
  // Clock and reset
  input wire logic     sys_clk,
  input wire logic     sys_rst,
  // Issue side
  input wire logic     req_valid,
  input wire lpt_req_s req,
  input wire logic     req_young,
  input wire logic     req_paired,
  input wire logic     cache_hit,
  // Answers
  input wire logic     req_accept,
  input wire logic     req_stall,
  input wire logic     data_ready,
  input wire logic     base_ready,
  input wire logic     pipe_flush
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  lpt_req_s pr;  // Request seen at the issue edge
  logic     py;  // Its younger slot flag
  logic     pp;  // Its paired flag
  // Keep the request that an accept refers to
  always_ff @(posedge sys_clk) begin
    {pr, py, pp} <= {req, req_young, req_paired};
  end
  lat_single_a: assert property (
    req_accept && pr.cls == LPT_SINGLE && pr[7:5] == 3'h0
    ##1 !req_accept [*2] |-> data_ready) else $error("single latency");
  lat_fwd_a: assert property (
    req_accept && pr.cls == LPT_SINGLE && pr[7:5] == 3'h2
    ##1 !req_accept |-> data_ready) else $error("forward latency");
  lat_unal_a: assert property (
    req_accept && pr.cls == LPT_SINGLE && pr[7:5] == 3'h1
    ##1 !req_accept [*3] |-> data_ready) else $error("unaligned latency");
  lat_cpx_a: assert property (
    req_accept && pr.cls == LPT_SINGLE_CPX && pr[7:5] == 3'h0
    ##1 !req_accept [*4] |-> data_ready) else $error("complex latency");
  lat_pre_a: assert property (
    req_accept && pr.cls == LPT_PRELOAD |-> data_ready)
    else $error("preload latency");
  gap_three_a: assert property (
    req_accept && pr.cls inside {LPT_SINGLE_CPX, LPT_PRELOAD_CPX}
    |=> !req_accept [*2]) else $error("repeat gap");
  base_one_a: assert property (
    req_accept && pr.cls == LPT_SINGLE && pr.wback |-> base_ready)
    else $error("base latency");
  issue_alone_a: assert property (
    req_accept && pp |-> !(pr.cls inside {LPT_ACQ_PAIR, LPT_DUAL_WORD,
    LPT_PAIR_SW, LPT_MULTI})) else $error("paired lone class");
  young_only_a: assert property (
    req_accept && pp && pr.cls inside {LPT_SINGLE_CPX, LPT_ACQUIRE}
    |-> py) else $error("older slot taken");
  miss_refuse_a: assert property (
    req_valid && !cache_hit |=> req_stall && !req_accept)
    else $error("miss taken");
  flush_after_a: assert property (
    pipe_flush |-> $past(data_ready)) else $error("flush timing");
endmodule

bind lpt_load_timing lpt_load_timing_chk chk (.sys_clk, .sys_rst,
  .req_valid, .req, .req_young, .req_paired, .cache_hit, .req_accept,
  .req_stall, .data_ready, .base_ready, .pipe_flush);

// *** test/tb.sv ***
// Self-checking bench for the load timing block
`timescale 1ns/1ps
module tb
  import lpt_pkg::*;
;
  logic     sys_clk = 1'b0;    // Core clock
  logic     sys_rst = 1'b1;    // Sync reset
  logic     req_valid = 1'b0;  // Request present
  lpt_req_s req = '0;          // Request fields
  logic     req_young = 1'b0;  // Younger slot
  logic     req_paired = 1'b0; // Paired issue
  logic     miss = 1'b0;       // Forced miss
  logic     cache_hit;         // From cache model
  logic     req_accept, req_stall, data_ready, base_ready, pipe_flush;
  int       mismatches = 0;
  int       cmp_count = 0;
  int       cyc = 0;
  lpt_cache_model cm (.miss, .cache_hit);
  lpt_load_timing dut (.sys_clk, .sys_rst, .req_valid, .req, .req_young,
    .req_paired, .cache_hit, .req_accept, .req_stall, .data_ready,
    .base_ready, .pipe_flush);
  // Clock
  initial forever #25 sys_clk = ~sys_clk;
  // Hang guard
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      mismatches++;
      end_of_test();
    end
  end
  // Compare and report
  task automatic chk(string n, logic [4:0] e, logic [4:0] s);
    cmp_count++;
    if (s !== e) begin
      mismatches++;
      $display("ERROR %s exp %0d got %0d", n, e, s);
    end
  endtask
  // One request, then timing of every answer
  task automatic shot(lpt_class_e c, logic [3:0] f, logic [4:0] n,
    logic [1:0] yp, logic m, logic [4:0] el, logic [4:0] eb);
    logic [4:0] dk, bk, fk;
    dk = 5'h0;
    bk = 5'h0;
    fk = 5'h0;
    @(negedge sys_clk);
    req = {c, f, n};
    {req_young, req_paired} = yp;
    miss = m;
    req_valid = 1'b1;
    for (int k = 1; k < 15; k++) begin
      @(negedge sys_clk);
      req_valid = 1'b0;
      miss = 1'b0;
      if (k == 1) chk("accept", 5'(el != 5'h0), 5'(req_accept));
      if (k == 1) chk("stall", 5'(el == 5'h0), 5'(req_stall));
      if (data_ready === 1'b1 && dk == 5'h0) dk = 5'(k);
      if (base_ready === 1'b1 && bk == 5'h0) bk = 5'(k);
      if (pipe_flush === 1'b1 && fk == 5'h0) fk = 5'(k);
    end
    chk("data", el, dk);
    chk("base", eb, bk);
    chk("flush", (f[2] && el != 5'h0) ? el + 5'h1 : 5'h0, fk);
  endtask
  // Held request: takes only at the repeat spacing
  task automatic rep(lpt_class_e c, logic [4:0] n, int g);
    @(negedge sys_clk);
    req = {c, 4'h0, n};
    {req_young, req_paired} = 2'h0;
    req_valid = 1'b1;
    for (int k = 1; k <= g + 1; k++) begin
      @(negedge sys_clk);
      if (k == g + 1) req_valid = 1'b0;
      chk("repeat", 5'(k == 1 || k == g + 1), 5'(req_accept));
    end
    repeat (14) @(negedge sys_clk);
  endtask
  // Every class unpaired, older paired, younger paired
  task automatic t_table;
    logic [1:0] sc [11] = '{2'h3, 2'h1, 2'h3, 2'h1, 2'h1, 2'h0, 2'h0,
      2'h0, 2'h1, 2'h0, 2'h0};
    logic [4:0] lt [11] = '{5'h3, 5'h5, 5'h1, 5'h3, 5'h3, 5'h3, 5'h3,
      5'h3, 5'h4, 5'h3, 5'h3};
    logic [1:0] yp [3] = '{2'h0, 2'h1, 2'h3};
    for (int i = 0; i < 11; i++) begin
      for (int j = 0; j < 3; j++) begin
        shot(lpt_class_e'(i[3:0]), 4'h0, 5'h1, yp[j], 1'b0,
          (j == 0 || sc[i][j == 1]) ? lt[i] : 5'h0, 5'h0);
      end
    end
  endtask
  // Forward, unaligned and writeback variants
  task automatic t_mod;
    shot(LPT_SINGLE, 4'h2, 5'h1, 2'h0, 1'b0, 5'h2, 5'h0);
    shot(LPT_SINGLE_CPX, 4'h2, 5'h1, 2'h0, 1'b0, 5'h4, 5'h0);
    shot(LPT_PAIR_X, 4'h2, 5'h1, 2'h0, 1'b0, 5'h3, 5'h0);
    shot(LPT_PAIR_SW, 4'h2, 5'h1, 2'h0, 1'b0, 5'h3, 5'h0);
    shot(LPT_SINGLE, 4'h1, 5'h1, 2'h0, 1'b0, 5'h4, 5'h0);
    shot(LPT_PAIR_X, 4'h1, 5'h1, 2'h0, 1'b0, 5'h5, 5'h0);
    shot(LPT_SINGLE, 4'h8, 5'h1, 2'h0, 1'b0, 5'h3, 5'h1);
    shot(LPT_SINGLE_CPX, 4'h8, 5'h1, 2'h0, 1'b0, 5'h5, 5'h3);
    shot(LPT_PAIR_X, 4'h8, 5'h1, 2'h3, 1'b0, 5'h0, 5'h0);
    shot(LPT_PAIR_X, 4'h8, 5'h1, 2'h0, 1'b0, 5'h4, 5'h2);
    shot(LPT_PAIR_W, 4'h8, 5'h1, 2'h0, 1'b0, 5'h3, 5'h1);
    shot(LPT_MULTI, 4'h8, 5'h5, 2'h0, 1'b0, 5'h5, 5'h3);
  endtask
  // Program counter loads flush and issue alone
  task automatic t_pc;
    shot(LPT_SINGLE, 4'h4, 5'h1, 2'h0, 1'b0, 5'h8, 5'h0);
    shot(LPT_SINGLE_CPX, 4'h4, 5'h1, 2'h0, 1'b0, 5'ha, 5'h0);
    shot(LPT_MULTI, 4'h4, 5'h3, 2'h0, 1'b0, 5'h9, 5'h0);
    shot(LPT_SINGLE, 4'h4, 5'h1, 2'h3, 1'b0, 5'h0, 5'h0);
  endtask
  // Repeat spacing per class
  task automatic t_rep;
    rep(LPT_SINGLE, 5'h1, 1);
    rep(LPT_SINGLE_CPX, 5'h1, 3);
    rep(LPT_PRELOAD_CPX, 5'h1, 3);
    rep(LPT_PAIR_X, 5'h1, 2);
    rep(LPT_MULTI, 5'h5, 3);
  endtask
  // Closing verdict
  task automatic end_of_test;
    if (mismatches == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (3) @(negedge sys_clk);
    sys_rst = 1'b0;
    t_table();
    t_mod();
    t_pc();
    t_rep();
    shot(LPT_SINGLE, 4'h0, 5'h1, 2'h0, 1'b1, 5'h0, 5'h0);
    end_of_test();
  end
endmodule
